// ### pkg/cps_pkg.sv
// constants, op codes and state codes for the pointer and stack state block
// Function
// RQ1 - 14-bit instruction pointer cleared to 0x0000 by reset
// RQ2 - fetch advances low 8 bits, no carry upward
// RQ3 - page advance op increments upper 6 bits
// RQ4 - pointer advances once per fetched instruction byte
// RQ5 - call or interrupt saves two-byte pointer and flags
// RQ6 - flags restored only by interrupt return op
// RQ7 - no direct firmware access to instruction pointer
// RQ8 - reset clears call stack pointer, grows upward
// RQ9 - load call stack pointer from accumulator
// RQ10 - interrupt entry: disable, write, increment, write, increment
// RQ11 - interrupt return: decrement, read twice, then enable
// RQ12 - call pushes pointer and flags, pointer plus two
// RQ13 - return reloads pointer, flags kept, pointer minus two
// RQ14 - push pre-decrements data stack pointer, then writes
// RQ15 - pop reads at data stack pointer, then increments
// RQ16 - data stack pointer resets zero, first push 0xff
// RQ17 - firmware keeps data stack within 0x00 to 0x4f
// RQ18 - swap accumulator with data stack pointer
// RQ19 - immediate operand is second instruction byte
// RQ20 - direct operand read from one-byte RAM address
// RQ21 - indexed address is constant plus index register
// RQ22 - stack pointers 8 bits, wrap silently modulo 256
// RQ23 - fixed two-byte layout of saved pointer and flags
package cps_pkg;

    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int IP_W = 14;
    localparam int LOW_W = 8;
    localparam int PAGE_W = 6;
    localparam int PTR_W = 8;
    localparam int DATA_W = 8;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [IP_W-1:0] IP_RST = 14'h0000;
    localparam logic [PTR_W-1:0] CSP_RST = 8'h00;
    localparam logic [PTR_W-1:0] DSP_RST = 8'h00;
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [DATA_W-1:0] IDX_RST = 8'h00;
    localparam logic INTEN_RST = 1'b0;

    // ----------------------------------------
    // saved byte layout: first byte is ip[7:0], second holds flags and ip[13:8]
    // ----------------------------------------
    localparam int SAVE_CARRY_BIT = 7;
    localparam int SAVE_ZERO_BIT = 6;
    localparam int SAVE_PAGE_MSB = 5;

    // ----------------------------------------
    // operations issued by the decoder
    // ----------------------------------------
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_PAGE_ADVANCE = 4'h1,
        OP_CALL = 4'h2,
        OP_INT_ACK = 4'h3,
        OP_RET = 4'h4,
        OP_INTERRUPT_RETURN = 4'h5,
        OP_PUSH = 4'h6,
        OP_POP = 4'h7,
        OP_LOAD_CALL_STACK_PTR = 4'h8,
        OP_SWAP_A_DSP = 4'h9,
        OP_OPND_IMM = 4'ha,
        OP_OPND_DIRECT = 4'hb,
        OP_OPND_INDEXED = 4'hc,
        OP_INT_ENABLE = 4'hd,
        OP_INT_DISABLE = 4'he,
        OP_RSVD = 4'hf
    } cps_op_e;

    // ----------------------------------------
    // sequencer states, one-hot
    // ----------------------------------------
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_SAVE_HI = 8'h02,
        ST_HI_WAIT = 8'h04,
        ST_HI_CAP = 8'h08,
        ST_LO_WAIT = 8'h10,
        ST_LO_CAP = 8'h20,
        ST_RD_WAIT = 8'h40,
        ST_RD_CAP = 8'h80
    } cps_state_e;

endpackage

// ### logic/cps_wrap_ptr.sv
// 8-bit stack pointer with increment, decrement and load, wrapping silently
`timescale 1ns/1ps
module cps_wrap_ptr #(
    parameter logic [cps_pkg::PTR_W-1:0] RST_VAL = cps_pkg::CSP_RST
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic inc,
    input wire logic dec,
    input wire logic load,
    input wire logic [cps_pkg::PTR_W-1:0] load_val,
    output logic [cps_pkg::PTR_W-1:0] ptr
);

    logic [cps_pkg::PTR_W-1:0] next_ptr;

    // load wins over stepping; the sequencer never asks for both
    // RQ22 modulo 256 wrap
    always_comb begin
        next_ptr = ptr;
        if (load) begin
            next_ptr = load_val;
        end else if (inc) begin
            next_ptr = cps_pkg::PTR_W'(ptr + 8'h01);
        end else if (dec) begin
            next_ptr = cps_pkg::PTR_W'(ptr - 8'h01);
        end
    end

    // register only
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ptr <= RST_VAL;
        end else begin
            ptr <= next_ptr;
        end
    end

endmodule

// ### logic/cps_ip_counter.sv
// 14-bit instruction pointer with paged low-byte increment
`timescale 1ns/1ps
module cps_ip_counter (
    input wire logic clk,
    input wire logic rstn,
    input wire logic step,
    input wire logic page_adv,
    input wire logic load,
    input wire logic [cps_pkg::IP_W-1:0] load_val,
    output logic [cps_pkg::IP_W-1:0] ip
);

    logic [cps_pkg::LOW_W-1:0] next_low;
    logic [cps_pkg::PAGE_W-1:0] next_page;

    // low byte and page advance separately; a load from the stack overrides both
    always_comb begin
        next_low = ip[cps_pkg::LOW_W-1:0];
        next_page = ip[cps_pkg::IP_W-1:cps_pkg::LOW_W];
        if (load) begin
            next_low = load_val[cps_pkg::LOW_W-1:0];
            next_page = load_val[cps_pkg::IP_W-1:cps_pkg::LOW_W];
        end else begin
            // RQ2 RQ4 low byte, per fetch
            if (step) begin
                next_low = cps_pkg::LOW_W'(ip[cps_pkg::LOW_W-1:0] + 8'h01);
            end
            // RQ3 page advance
            if (page_adv) begin
                next_page = cps_pkg::PAGE_W'(ip[cps_pkg::IP_W-1:cps_pkg::LOW_W] + 6'h01);
            end
        end
    end

    // RQ1 reset to zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ip <= cps_pkg::IP_RST;
        end else begin
            ip <= {next_page, next_low};
        end
    end

endmodule

// ### logic/cps_core_state.sv
// architectural pointers, stacks and operand addressing of the core
`timescale 1ns/1ps
module cps_core_state (
    input wire logic clk,
    input wire logic rstn,
    // decoder side
    input wire logic fetch_byte,
    input wire logic op_start,
    input wire logic [3:0] op_code,
    input wire logic op_sel_x,
    input wire logic [cps_pkg::DATA_W-1:0] op_imm,
    input wire logic [cps_pkg::IP_W-1:0] op_target,
    output logic op_ready,
    output logic op_done,
    // alu side
    input wire logic acc_we,
    input wire logic [cps_pkg::DATA_W-1:0] acc_wdata,
    input wire logic idx_we,
    input wire logic [cps_pkg::DATA_W-1:0] idx_wdata,
    input wire logic flag_we,
    input wire logic carry_in,
    input wire logic zero_in,
    output logic [cps_pkg::DATA_W-1:0] accumulator,
    output logic [cps_pkg::DATA_W-1:0] index_reg,
    output logic carry,
    output logic zero,
    output logic int_enable,
    output logic [cps_pkg::DATA_W-1:0] opnd_data,
    output logic opnd_valid,
    // program memory
    output logic [cps_pkg::IP_W-1:0] instruction_pointer,
    // data sram, read data valid the cycle after ram_re
    output logic [cps_pkg::DATA_W-1:0] ram_addr,
    output logic [cps_pkg::DATA_W-1:0] ram_wdata,
    output logic ram_we,
    output logic ram_re,
    input wire logic [cps_pkg::DATA_W-1:0] ram_rdata,
    // visible pointer state
    output logic [cps_pkg::PTR_W-1:0] call_stack_pointer,
    output logic [cps_pkg::PTR_W-1:0] data_stack_pointer
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    cps_pkg::cps_state_e state, next_state;
    logic [cps_pkg::DATA_W-1:0] hold, next_hold;
    logic [cps_pkg::IP_W-1:0] target, next_target;
    logic rd_pop, next_rd_pop;
    logic rd_pop_x, next_rd_pop_x;
    logic ret_flags, next_ret_flags;
    logic [cps_pkg::DATA_W-1:0] next_ram_addr, next_ram_wdata;
    logic next_ram_we, next_ram_re;
    logic [cps_pkg::DATA_W-1:0] next_acc, next_idx, next_opnd;
    logic next_carry, next_zero, next_inten, next_opnd_valid, next_done;
    logic csp_inc, csp_dec, csp_load;
    logic dsp_inc, dsp_dec, dsp_load;
    logic ip_load, page_adv;
    logic [cps_pkg::IP_W-1:0] ip_load_val;
    logic [cps_pkg::PTR_W-1:0] csp_m1, dsp_m1;
    cps_pkg::cps_op_e op;

    assign op = cps_pkg::cps_op_e'(op_code);
    // RQ22 pre-decremented addresses wrap
    assign csp_m1 = cps_pkg::PTR_W'(call_stack_pointer - 8'h01);
    assign dsp_m1 = cps_pkg::PTR_W'(data_stack_pointer - 8'h01);
    // handshake is combinational so a new op can follow done back to back
    assign op_ready = (state == cps_pkg::ST_IDLE);

    // ----------------------------------------
    // pointer registers
    // ----------------------------------------
    // RQ8 call stack starts at zero
    cps_wrap_ptr #(
        .RST_VAL(cps_pkg::CSP_RST)
    ) u_csp (
        .clk(clk),
        .rstn(rstn),
        .inc(csp_inc),
        .dec(csp_dec),
        .load(csp_load),
        .load_val(accumulator),
        .ptr(call_stack_pointer)
    );

    // RQ16 data stack starts at zero
    cps_wrap_ptr #(
        .RST_VAL(cps_pkg::DSP_RST)
    ) u_dsp (
        .clk(clk),
        .rstn(rstn),
        .inc(dsp_inc),
        .dec(dsp_dec),
        .load(dsp_load),
        .load_val(accumulator),
        .ptr(data_stack_pointer)
    );

    // RQ7 ip only moves by fetch, page advance or stack and target loads
    cps_ip_counter u_ip (
        .clk(clk),
        .rstn(rstn),
        .step(fetch_byte),
        .page_adv(page_adv),
        .load(ip_load),
        .load_val(ip_load_val),
        .ip(instruction_pointer)
    );

    // ----------------------------------------
    // sequencer next state
    // ----------------------------------------
    // alu writes land first; a stack op touching the same register overrides them
    always_comb begin
        next_state = state;
        next_hold = hold;
        next_target = target;
        next_rd_pop = rd_pop;
        next_rd_pop_x = rd_pop_x;
        next_ret_flags = ret_flags;
        next_ram_addr = ram_addr;
        next_ram_wdata = ram_wdata;
        next_ram_we = 1'b0;
        next_ram_re = 1'b0;
        next_acc = acc_we ? acc_wdata : accumulator;
        next_idx = idx_we ? idx_wdata : index_reg;
        next_carry = flag_we ? carry_in : carry;
        next_zero = flag_we ? zero_in : zero;
        next_inten = int_enable;
        next_opnd = opnd_data;
        next_opnd_valid = 1'b0;
        next_done = 1'b0;
        csp_inc = 1'b0;
        csp_dec = 1'b0;
        csp_load = 1'b0;
        dsp_inc = 1'b0;
        dsp_dec = 1'b0;
        dsp_load = 1'b0;
        ip_load = 1'b0;
        ip_load_val = target;
        page_adv = 1'b0;
        case (state)
            cps_pkg::ST_IDLE: begin
                if (op_start) begin
                    case (op)
                        cps_pkg::OP_CALL, cps_pkg::OP_INT_ACK: begin
                            // RQ10 interrupts off at entry
                            if (op == cps_pkg::OP_INT_ACK) begin
                                next_inten = 1'b0;
                            end
                            // RQ5 first byte is the low pointer byte
                            next_ram_addr = call_stack_pointer;
                            next_ram_wdata = instruction_pointer[cps_pkg::LOW_W-1:0];
                            next_ram_we = 1'b1;
                            csp_inc = 1'b1;
                            // RQ23 second byte packs flags over the page bits
                            next_hold = {carry, zero,
                                instruction_pointer[cps_pkg::IP_W-1:cps_pkg::LOW_W]};
                            next_target = op_target;
                            next_state = cps_pkg::ST_SAVE_HI;
                        end
                        cps_pkg::OP_RET, cps_pkg::OP_INTERRUPT_RETURN: begin
                            // RQ11 decrement before the second byte is read
                            csp_dec = 1'b1;
                            next_ram_addr = csp_m1;
                            next_ram_re = 1'b1;
                            next_ret_flags = (op == cps_pkg::OP_INTERRUPT_RETURN);
                            next_state = cps_pkg::ST_HI_WAIT;
                        end
                        cps_pkg::OP_PUSH: begin
                            // RQ14 pre-decrement then write
                            dsp_dec = 1'b1;
                            next_ram_addr = dsp_m1;
                            next_ram_wdata = op_sel_x ? index_reg : accumulator;
                            next_ram_we = 1'b1;
                            next_done = 1'b1;
                        end
                        cps_pkg::OP_POP: begin
                            // RQ15 read at pointer, post-increment
                            next_ram_addr = data_stack_pointer;
                            next_ram_re = 1'b1;
                            dsp_inc = 1'b1;
                            next_rd_pop = 1'b1;
                            next_rd_pop_x = op_sel_x;
                            next_state = cps_pkg::ST_RD_WAIT;
                        end
                        cps_pkg::OP_OPND_DIRECT: begin
                            // RQ20 address carried in the instruction
                            next_ram_addr = op_imm;
                            next_ram_re = 1'b1;
                            next_rd_pop = 1'b0;
                            next_state = cps_pkg::ST_RD_WAIT;
                        end
                        cps_pkg::OP_OPND_INDEXED: begin
                            // RQ21 constant plus index, wraps in 8 bits
                            next_ram_addr = cps_pkg::DATA_W'(op_imm + index_reg);
                            next_ram_re = 1'b1;
                            next_rd_pop = 1'b0;
                            next_state = cps_pkg::ST_RD_WAIT;
                        end
                        cps_pkg::OP_OPND_IMM: begin
                            // RQ19 second byte is the value
                            next_opnd = op_imm;
                            next_opnd_valid = 1'b1;
                            next_done = 1'b1;
                        end
                        cps_pkg::OP_LOAD_CALL_STACK_PTR: begin
                            // RQ9 call stack pointer from accumulator
                            csp_load = 1'b1;
                            next_done = 1'b1;
                        end
                        cps_pkg::OP_SWAP_A_DSP: begin
                            // RQ18 exchange in one cycle
                            next_acc = data_stack_pointer;
                            dsp_load = 1'b1;
                            next_done = 1'b1;
                        end
                        cps_pkg::OP_PAGE_ADVANCE: begin
                            // RQ3 page bits step on this op only
                            page_adv = 1'b1;
                            next_done = 1'b1;
                        end
                        cps_pkg::OP_INT_ENABLE: begin
                            next_inten = 1'b1;
                            next_done = 1'b1;
                        end
                        cps_pkg::OP_INT_DISABLE: begin
                            next_inten = 1'b0;
                            next_done = 1'b1;
                        end
                        default: begin
                            next_done = 1'b1;
                        end
                    endcase
                end
            end
            cps_pkg::ST_SAVE_HI: begin
                // RQ12 second write and second increment, then jump
                next_ram_addr = call_stack_pointer;
                next_ram_wdata = hold;
                next_ram_we = 1'b1;
                csp_inc = 1'b1;
                ip_load = 1'b1;
                ip_load_val = target;
                next_done = 1'b1;
                next_state = cps_pkg::ST_IDLE;
            end
            cps_pkg::ST_HI_WAIT: begin
                next_state = cps_pkg::ST_HI_CAP;
            end
            cps_pkg::ST_HI_CAP: begin
                // RQ11 second decrement, first byte next
                next_hold = ram_rdata;
                csp_dec = 1'b1;
                next_ram_addr = csp_m1;
                next_ram_re = 1'b1;
                next_state = cps_pkg::ST_LO_WAIT;
            end
            cps_pkg::ST_LO_WAIT: begin
                next_state = cps_pkg::ST_LO_CAP;
            end
            cps_pkg::ST_LO_CAP: begin
                // RQ13 pointer reloaded for both returns
                ip_load = 1'b1;
                ip_load_val = {hold[cps_pkg::SAVE_PAGE_MSB:0], ram_rdata};
                // RQ6 flags and enable only on interrupt return
                if (ret_flags) begin
                    next_carry = hold[cps_pkg::SAVE_CARRY_BIT];
                    next_zero = hold[cps_pkg::SAVE_ZERO_BIT];
                    next_inten = 1'b1;
                end
                next_done = 1'b1;
                next_state = cps_pkg::ST_IDLE;
            end
            cps_pkg::ST_RD_WAIT: begin
                next_state = cps_pkg::ST_RD_CAP;
            end
            cps_pkg::ST_RD_CAP: begin
                next_opnd = ram_rdata;
                next_opnd_valid = 1'b1;
                if (rd_pop) begin
                    if (rd_pop_x) begin
                        next_idx = ram_rdata;
                    end else begin
                        next_acc = ram_rdata;
                    end
                end
                next_done = 1'b1;
                next_state = cps_pkg::ST_IDLE;
            end
            default: begin
                next_state = cps_pkg::ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // sequencer registers
    // ----------------------------------------
    // register only; all values computed above
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= cps_pkg::ST_IDLE;
            hold <= 8'h00;
            target <= cps_pkg::IP_RST;
            rd_pop <= 1'b0;
            rd_pop_x <= 1'b0;
            ret_flags <= 1'b0;
            ram_addr <= 8'h00;
            ram_wdata <= 8'h00;
            ram_we <= 1'b0;
            ram_re <= 1'b0;
            accumulator <= cps_pkg::ACC_RST;
            index_reg <= cps_pkg::IDX_RST;
            carry <= 1'b0;
            zero <= 1'b0;
            int_enable <= cps_pkg::INTEN_RST;
            opnd_data <= 8'h00;
            opnd_valid <= 1'b0;
            op_done <= 1'b0;
        end else begin
            state <= next_state;
            hold <= next_hold;
            target <= next_target;
            rd_pop <= next_rd_pop;
            rd_pop_x <= next_rd_pop_x;
            ret_flags <= next_ret_flags;
            ram_addr <= next_ram_addr;
            ram_wdata <= next_ram_wdata;
            ram_we <= next_ram_we;
            ram_re <= next_ram_re;
            accumulator <= next_acc;
            index_reg <= next_idx;
            carry <= next_carry;
            zero <= next_zero;
            int_enable <= next_inten;
            opnd_data <= next_opnd;
            opnd_valid <= next_opnd_valid;
            op_done <= next_done;
        end
    end

endmodule

// ### bench/cps_core_state_asserts.sv
// concurrent checks on the pointer and stack state block
`timescale 1ns/1ps
module cps_core_state_asserts (
    input wire logic clk,
    input wire logic rstn,
    input wire logic fetch_byte,
    input wire logic op_start,
    input wire logic [3:0] op_code,
    input wire logic op_ready,
    input wire logic op_done,
    input wire logic carry,
    input wire logic int_enable,
    input wire logic [13:0] instruction_pointer,
    input wire logic [7:0] ram_addr,
    input wire logic ram_we,
    input wire logic ram_re,
    input wire logic [7:0] ram_rdata,
    input wire logic [7:0] call_stack_pointer,
    input wire logic [7:0] data_stack_pointer
);
    logic take;
    logic [13:0] ip;

    // an op counts only when the decoder handshake accepts it
    assign take = op_start && op_ready;
    assign ip = instruction_pointer;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_reset_state: assert property (rstn && !$past(rstn) |->
        ip == 14'h0000 && call_stack_pointer == 8'h00 && data_stack_pointer == 8'h00)
        else $error("state not cleared by reset");
    a_fetch_low: assert property (fetch_byte && op_ready && !op_start |=>
        ip == {$past(ip[13:8]), $past(ip[7:0]) + 8'h01})
        else $error("fetch stepped more than the low byte");
    a_page_step: assert property (take && op_code == 4'h1 && !fetch_byte |=>
        ip == {$past(ip[13:8]) + 6'h01, $past(ip[7:0])})
        else $error("page advance wrong");
    a_call_push: assert property (take && op_code == 4'h2 |=> ram_we &&
        ram_addr == $past(call_stack_pointer) ##1 ram_we && op_done &&
        call_stack_pointer == ram_addr + 8'h01 && ram_addr == $past(ram_addr) + 8'h01)
        else $error("call did not push two bytes");
    a_intack_off: assert property (take && op_code == 4'h3 |=> !int_enable && ram_we
        ##1 ram_we && op_done && call_stack_pointer == $past(call_stack_pointer, 2) + 8'h02)
        else $error("interrupt entry wrong");
    a_interrupt_return_op_order: assert property (take && op_code == 4'h5 |=> ram_re &&
        ram_addr == call_stack_pointer ##2 ram_re && ram_addr == call_stack_pointer ##2
        op_done && int_enable && carry == $past(ram_rdata[7], 3))
        else $error("interrupt return wrong");
    a_push_first: assert property (take && op_code == 4'h6 |=> ram_we && op_done &&
        data_stack_pointer == $past(data_stack_pointer) - 8'h01 && ram_addr == data_stack_pointer)
        else $error("push not pre-decremented");
    a_pop_after: assert property (take && op_code == 4'h7 |=> ram_re &&
        ram_addr == $past(data_stack_pointer) && data_stack_pointer == ram_addr + 8'h01
        ##2 op_done)
        else $error("pop not post-incremented");

    c_intack: cover property (take && op_code == 4'h3);
    c_interrupt_return_op: cover property (take && op_code == 4'h5);
    c_push: cover property (take && op_code == 4'h6);
endmodule

bind cps_core_state cps_core_state_asserts i_cps_asserts (.clk, .rstn, .fetch_byte, .op_start,
    .op_code, .op_ready, .op_done, .carry, .int_enable, .instruction_pointer, .ram_addr, .ram_we,
    .ram_re, .ram_rdata, .call_stack_pointer, .data_stack_pointer);

// ### bench/cps_sram_model.sv
// data sram partner with one cycle read latency
`timescale 1ns/1ps
module cps_sram_model (
    input wire logic clk,
    input wire logic [7:0] ram_addr,
    input wire logic [7:0] ram_wdata,
    input wire logic ram_we,
    input wire logic ram_re,
    output logic [7:0] ram_rdata
);
    logic [7:0] mem [256];

    initial ram_rdata = 8'h00;
    // read data holds one cycle, then toggles so stale data is never trusted
    always @(posedge clk) begin
        if (ram_we) begin
            mem[ram_addr] <= ram_wdata;
        end
        ram_rdata <= ram_re ? mem[ram_addr] : ~ram_rdata;
    end
endmodule

// ### bench/tb.sv
// self-checking bench for the pointer and stack state block
`timescale 1ns/1ps
`define CHK(a, b) \
    tests_run++; \
    if ((a) !== (b)) begin \
        mismatches++; \
        $display("Error t=%0t got %h exp %h", $time, (a), (b)); \
    end
module tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic fetch_byte = 1'b0, op_start = 1'b0, op_sel_x = 1'b0, acc_we = 1'b0;
    logic flag_we = 1'b0, carry_in = 1'b0, zero_in = 1'b0;
    logic op_ready, op_done, carry, zero, int_enable, opnd_valid, ram_we, ram_re;
    logic [3:0] op_code = 4'h0;
    logic [7:0] op_imm = 8'h00, acc_wdata = 8'h00, accumulator, index_reg, opnd_data;
    logic [7:0] ram_addr, ram_wdata, ram_rdata, call_stack_pointer, data_stack_pointer;
    logic [13:0] op_target = 14'h0000, instruction_pointer;
    int mismatches = 0;
    int tests_run = 0;

    always #5 clk = ~clk;

    cps_core_state i_cps_core_state (.clk, .rstn, .fetch_byte, .op_start, .op_code, .op_sel_x,
        .op_imm, .op_target, .op_ready, .op_done, .acc_we, .acc_wdata, .idx_we(1'b0),
        .idx_wdata(8'h00), .flag_we, .carry_in, .zero_in, .accumulator, .index_reg, .carry,
        .zero, .int_enable, .opnd_data, .opnd_valid, .instruction_pointer, .ram_addr,
        .ram_wdata, .ram_we, .ram_re, .ram_rdata, .call_stack_pointer, .data_stack_pointer);
    cps_sram_model i_cps_sram_model (.clk, .ram_addr, .ram_wdata, .ram_we, .ram_re, .ram_rdata);

    // one op, then a bounded wait for its completion pulse
    task automatic run_op(input logic [3:0] c, input logic [7:0] im, input logic [13:0] t);
        // one idle edge first, so op_start is never lowered and raised in one step
        @(posedge clk);
        #1;
        op_code = c;
        op_imm = im;
        op_target = t;
        op_start = 1'b1;
        @(posedge clk);
        #1;
        op_start = 1'b0;
        for (int n = 0; n < 6 && op_done !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        `CHK(op_done, 1'b1)
    endtask

    // alu-side write of accumulator and flags
    task automatic alu(input logic [7:0] a, input logic c, input logic z);
        acc_wdata = a;
        carry_in = c;
        zero_in = z;
        acc_we = 1'b1;
        flag_we = 1'b1;
        @(posedge clk);
        #1;
        acc_we = 1'b0;
        flag_we = 1'b0;
    endtask

    // reset state, low byte wrap without carry, page advance
    task automatic t_fetch;
        `CHK(instruction_pointer, 14'h0000)
        `CHK(call_stack_pointer, 8'h00)
        fetch_byte = 1'b1;
        repeat (256) @(posedge clk);
        #1;
        `CHK(instruction_pointer, 14'h0000)
        repeat (2) @(posedge clk);
        #1;
        fetch_byte = 1'b0;
        `CHK(instruction_pointer, 14'h0002)
        run_op(4'h1, 8'h00, 14'h0000);
        `CHK(instruction_pointer, 14'h0102)
    endtask

    // push at zero wraps to the top byte, pop into index, swap, direct read
    task automatic t_stack;
        `CHK(data_stack_pointer, 8'h00)
        alu(8'h5a, 1'b0, 1'b0);
        run_op(4'h6, 8'h00, 14'h0000);
        `CHK(data_stack_pointer, 8'hff)
        op_sel_x = 1'b1;
        run_op(4'h7, 8'h00, 14'h0000);
        op_sel_x = 1'b0;
        `CHK(index_reg, 8'h5a)
        `CHK(data_stack_pointer, 8'h00)
        // keep the data stack below the endpoint buffers
        alu(8'h20, 1'b0, 1'b0);
        run_op(4'h9, 8'h00, 14'h0000);
        `CHK(data_stack_pointer, 8'h20)
        `CHK(accumulator, 8'h00)
        run_op(4'hb, 8'hff, 14'h0000);
        `CHK({opnd_valid, opnd_data}, 9'h15a)
        run_op(4'ha, 8'h3c, 14'h0000);
        `CHK({opnd_valid, opnd_data}, 9'h13c)
    endtask

    // interrupt entry and return, call and return with flags changed between
    task automatic t_call;
        alu(8'h10, 1'b1, 1'b0);
        run_op(4'h8, 8'h00, 14'h0000);
        `CHK(call_stack_pointer, 8'h10)
        run_op(4'hd, 8'h00, 14'h0000);
        run_op(4'h3, 8'h00, 14'h0230);
        `CHK(int_enable, 1'b0)
        `CHK(instruction_pointer, 14'h0230)
        alu(8'h00, 1'b0, 1'b1);
        `CHK(i_cps_sram_model.mem[8'h11], 8'h81)
        run_op(4'h5, 8'h00, 14'h0000);
        `CHK({instruction_pointer, carry, zero, int_enable}, 17'h00815)
        `CHK(call_stack_pointer, 8'h10)
        run_op(4'he, 8'h00, 14'h0000);
        `CHK(int_enable, 1'b0)
        run_op(4'h2, 8'h00, 14'h0345);
        `CHK(call_stack_pointer, 8'h12)
        alu(8'h00, 1'b0, 1'b1);
        run_op(4'h4, 8'h00, 14'h0000);
        `CHK({instruction_pointer, carry, zero, call_stack_pointer}, 24'h040910)
        run_op(4'hc, 8'hb7, 14'h0000);
        `CHK(opnd_data, 8'h81)
    endtask

    task automatic close_out;
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        #1;
        rstn = 1'b1;
        t_fetch;
        t_stack;
        t_call;
        close_out;
    end

    // watchdog: the sequence needs about 310 cycles
    initial begin
        #20000;
        mismatches++;
        close_out;
    end
endmodule
